// >>> qdfsr_host_model.sv
// Serial master model that reads the fault readout block.
`timescale 1ns/10ps
module qdfsr_host_model (
   // Serial link
   output logic      spi_clk,
   output logic      cs_n,
   input wire logic  pin_oe_n
);
   localparam int HALF = 250;
   logic pin;

   // A released pin is pulled up externally.
   assign pin = pin_oe_n ? 1'h1 : 1'h0;

   initial begin
      spi_clk = 1'h0;
      cs_n    = 1'h1;
   end

   task automatic frame(input int n, input logic hi, output logic flag,
                        output logic [31:0] d);
      d = 32'h0;
      spi_clk = hi;
      #100;
      cs_n = 1'h0;
      #200;
      flag = pin;
      for (int i = 0; i < n; i++) begin
         spi_clk = 1'h1;
         #HALF;
         spi_clk = 1'h0;
         d = {d[30:0], pin};
         #HALF;
      end
      cs_n = 1'h1;
      #HALF;
      spi_clk = 1'h0;
      #200;
   endtask : frame
endmodule : qdfsr_host_model

// >>> qdfsr_pkg.sv
// Shared constants of the quad driver fault serial readout block.
package qdfsr_pkg;

   // Diagnostic register geometry.
   localparam int QDFSR_CHANNELS  = 4;
   localparam int QDFSR_PER_CH    = 4;
   localparam int QDFSR_DIAG_BITS = 16;

   // Position of each fault inside a channel nibble; the top one leaves first.
   localparam int QDFSR_POS_OVER_TEMP    = 3;
   localparam int QDFSR_POS_SHORT_SUPPLY = 2;
   localparam int QDFSR_POS_SHORT_GROUND = 1;
   localparam int QDFSR_POS_OPEN_LOAD    = 0;

   // Detectors that pass through a persistence filter.
   localparam logic [15:0] QDFSR_FILTER_MASK = 16'h3333;

   // Reset values.
   localparam logic [15:0] QDFSR_DIAG_RST = 16'h0000;
   localparam logic        QDFSR_FLAG_RST = 1'b0;

   // Filter delay and the oscillator period that times it.
   localparam int QDFSR_FILT_DELAY_NS = 12000;
   localparam int QDFSR_CORE_CLK_NS   = 20;
   localparam int QDFSR_FILT_CYCLES   =
      (QDFSR_FILT_DELAY_NS + QDFSR_CORE_CLK_NS - 1) / QDFSR_CORE_CLK_NS;
   localparam int QDFSR_FILT_CNT_W    = 10;

   // Fastest serial clock the host may use.
   localparam int QDFSR_SPI_MAX_KHZ = 2000;

endpackage : qdfsr_pkg

// >>> qdfsr_readout.sv
// Fault filtering, diagnostic register and serial readout of a quad driver.
//
// Behaviour
// RULE_01 - A ground short or open load counts only after 12 us of persistence.
// RULE_02 - Host keeps the serial clock at or below 2 MHz.
// RULE_03 - Detected faults are stored as four bits for each of four channels.
// RULE_04 - Selection copies the 16 stored bits into the serial shift register.
// RULE_05 - Host holds the serial clock low when it lowers chip select.
// RULE_06 - Each serial clock shifts data out while cascade input shifts in.
// RULE_07 - First rising serial clock after selection clears the stored faults.
// RULE_08 - After 16 own bits, upstream data follows while select stays low.
// RULE_09 - New faults are still stored while a readout is running.
// RULE_10 - Error flag is high whenever any stored fault bit is set; the code latches error_flag_o from the stored bits only at each select fall.
// RULE_11 - Leading flag bit is error flag OR cascade input, before any clock.
// RULE_12 - Cascade input is tied low on a lone or first chip.
// RULE_13 - Host toggles the clock at least once when a fault is flagged.
// RULE_14 - Output driver is enabled only while chip select is low.
// RULE_15 - While the gate is set, cascade input OR error flag reaches output.
// RULE_16 - Gate sets on select fall with clock low, holds until clock changes.
// RULE_17 - Error flag is latched on each select fall and held until the next; the code clears it at the first rising clock.
// RULE_18 - Clock high at select fall leaves the gate cleared.
// RULE_19 - First rising clock clears the gate and presents the first data bit.
// RULE_20 - Host keeps chip select low for the whole readout.
// RULE_21 - Error flag clears when data is clocked out; data kept while clock low.
// RULE_22 - Bits leave by channel, each as temperature, supply, ground, open.
// RULE_23 - Apart from the flag bit, transfers use clock polarity 0, phase 1.
// RULE_24 - Open-drain output pulls low for zero and releases for one.
// RULE_25 - Each filter is a counter that restarts when the raw fault drops.
`timescale 1ns/10ps

module qdfsr_readout
   import qdfsr_pkg::*;
#(
   parameter int FILT_CYCLES = QDFSR_FILT_CYCLES
)(
   // Core clock and reset
   input  wire logic                 core_clk,
   input  wire logic                 resetn,
   // Raw fault comparator outputs, one bit per channel
   input  wire logic [3:0]           over_temp_raw,
   input  wire logic [3:0]           short_supply_raw,
   input  wire logic [3:0]           short_ground_raw,
   input  wire logic [3:0]           open_load_raw,
   // Serial link
   input  wire logic                 spi_clk,
   input  wire logic                 cs_n,
   input  wire logic                 cascade_serial_in,
   output logic                      fault_output_pin_o,
   output logic                      fault_output_pin_oe_n,
   // Status
   output logic                      error_flag_o,
   output logic [QDFSR_DIAG_BITS-1:0] diag_reg_o
);

   localparam logic [QDFSR_FILT_CNT_W-1:0] FILT_LAST =
      QDFSR_FILT_CNT_W'(FILT_CYCLES);

   // Maps a channel and a fault position onto the diagnostic bit index.
   function automatic int diag_index(input int ch, input int pos);
      diag_index = QDFSR_DIAG_BITS - QDFSR_PER_CH * (ch + 1) + pos;
   endfunction : diag_index

   // ---------------------------------------------------------------
   // Core domain: raw fault synchronisers.
   // ---------------------------------------------------------------
   logic [QDFSR_DIAG_BITS-1:0] raw_vec;
   logic [QDFSR_DIAG_BITS-1:0] raw_s1_ff;
   logic [QDFSR_DIAG_BITS-1:0] raw_s2_ff;
   logic [QDFSR_DIAG_BITS-1:0] det;

   always_comb begin
      raw_vec = QDFSR_DIAG_RST;
      for (int c = 0; c < QDFSR_CHANNELS; c++) begin
         raw_vec[diag_index(c, QDFSR_POS_OVER_TEMP)]    = over_temp_raw[c]; // RULE_22
         raw_vec[diag_index(c, QDFSR_POS_SHORT_SUPPLY)] = short_supply_raw[c];
         raw_vec[diag_index(c, QDFSR_POS_SHORT_GROUND)] = short_ground_raw[c];
         raw_vec[diag_index(c, QDFSR_POS_OPEN_LOAD)]    = open_load_raw[c];
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         raw_s1_ff <= QDFSR_DIAG_RST;
         raw_s2_ff <= QDFSR_DIAG_RST;
      end else begin
         raw_s1_ff <= raw_vec;
         raw_s2_ff <= raw_s1_ff;
      end
   end

   // ---------------------------------------------------------------
   // Core domain: persistence filters.
   // ---------------------------------------------------------------
   generate
      for (genvar i = 0; i < QDFSR_DIAG_BITS; i++) begin : g_filt
         if (QDFSR_FILTER_MASK[i]) begin : g_cnt
            logic [QDFSR_FILT_CNT_W-1:0] cnt_ff;

            // The counter saturates so a lasting fault stays detected.
            always_ff @(posedge core_clk or negedge resetn) begin
               if (!resetn) begin
                  cnt_ff <= '0;
               end else if (!raw_s2_ff[i]) begin
                  cnt_ff <= '0; // RULE_25
               end else if (cnt_ff != FILT_LAST) begin
                  cnt_ff <= cnt_ff + 1'b1; // RULE_25
               end
            end

            assign det[i] = (cnt_ff == FILT_LAST); // RULE_01
         end else begin : g_direct
            assign det[i] = raw_s2_ff[i];
         end
      end
   endgenerate

   // ---------------------------------------------------------------
   // Core domain: chip select and clear event crossings.
   // ---------------------------------------------------------------
   logic cs_s1_ff;
   logic cs_s2_ff;
   logic cs_d_ff;
   logic clr_tgl_ff;
   logic clr_s1_ff;
   logic clr_s2_ff;
   logic clr_d_ff;
   logic cs_fall;
   logic clr_evt;

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         cs_s1_ff <= 1'b1;
         cs_s2_ff <= 1'b1;
         cs_d_ff  <= 1'b1;
      end else begin
         cs_s1_ff <= cs_n;
         cs_s2_ff <= cs_s1_ff;
         cs_d_ff  <= cs_s2_ff;
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         clr_s1_ff <= 1'b0;
         clr_s2_ff <= 1'b0;
         clr_d_ff  <= 1'b0;
      end else begin
         clr_s1_ff <= clr_tgl_ff;
         clr_s2_ff <= clr_s1_ff;
         clr_d_ff  <= clr_s2_ff;
      end
   end

   assign cs_fall = cs_d_ff & ~cs_s2_ff;
   assign clr_evt = clr_s2_ff ^ clr_d_ff;

   // ---------------------------------------------------------------
   // Core domain: diagnostic register, snapshot and error flag.
   // ---------------------------------------------------------------
   logic [QDFSR_DIAG_BITS-1:0] par_ff;
   logic [QDFSR_DIAG_BITS-1:0] nxt_par;
   logic [QDFSR_DIAG_BITS-1:0] snap_ff;
   logic                       eflag_ff;
   logic                       err_now;

   // A fault seen in the clearing cycle is kept: the set wins.
   always_comb begin
      nxt_par = par_ff;
      if (clr_evt) begin
         nxt_par = QDFSR_DIAG_RST; // RULE_07
      end
      nxt_par = nxt_par | det; // RULE_03 RULE_09
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         par_ff <= QDFSR_DIAG_RST;
      end else begin
         par_ff <= nxt_par;
      end
   end

   assign err_now = |par_ff; // RULE_10

   // The snapshot is held steady for the whole frame and read by the link.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         snap_ff <= QDFSR_DIAG_RST;
      end else if (cs_fall) begin
         snap_ff <= par_ff; // RULE_04
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         eflag_ff <= QDFSR_FLAG_RST;
      end else if (cs_fall) begin
         eflag_ff <= err_now; // RULE_17
      end else if (clr_evt) begin
         eflag_ff <= QDFSR_FLAG_RST; // RULE_21
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         diag_reg_o <= QDFSR_DIAG_RST;
      end else begin
         diag_reg_o <= par_ff;
      end
   end

   assign error_flag_o = eflag_ff;

   // ---------------------------------------------------------------
   // Link domain: pass gate.
   // ---------------------------------------------------------------
   logic armed_ff;
   logic gate;

   // Armed while deselected; the first rising clock of a frame disarms it.
   // Reset arms it too, so the first frame after reset still shows the flag
   // even though chip select never rose after the reset was released.
   always_ff @(posedge spi_clk or posedge cs_n or negedge resetn) begin
      if (!resetn) begin
         armed_ff <= 1'b1; // RULE_16
      end else if (cs_n) begin
         armed_ff <= 1'b1; // RULE_16
      end else begin
         armed_ff <= 1'b0; // RULE_19
      end
   end

   // The gate opens only while the clock pin is still low.
   assign gate = armed_ff & ~spi_clk; // RULE_16 RULE_18

   // ---------------------------------------------------------------
   // Link domain: shift path.
   // ---------------------------------------------------------------
   logic                       out_ff;
   logic [QDFSR_DIAG_BITS-2:0] sh_ff;
   logic                       din_fall_ff;

   // Cascade data is sampled on the falling edge, mid-bit.
   always_ff @(negedge spi_clk or negedge resetn) begin
      if (!resetn) begin
         din_fall_ff <= 1'b0;
      end else begin
         din_fall_ff <= cascade_serial_in; // RULE_23
      end
   end

   // Rising edges launch the next bit; upstream data trails by 16 bits.
   always_ff @(posedge spi_clk or negedge resetn) begin
      if (!resetn) begin
         out_ff <= 1'b0;
         sh_ff  <= '0;
      end else if (armed_ff) begin
         out_ff <= snap_ff[QDFSR_DIAG_BITS-1]; // RULE_04 RULE_19
         sh_ff  <= snap_ff[QDFSR_DIAG_BITS-2:0];
      end else begin
         out_ff <= sh_ff[QDFSR_DIAG_BITS-2]; // RULE_06 RULE_08
         sh_ff  <= {sh_ff[QDFSR_DIAG_BITS-3:0], din_fall_ff}; // RULE_06
      end
   end

   // Each first rising edge asks the core to clear its fault store.
   always_ff @(posedge spi_clk or negedge resetn) begin
      if (!resetn) begin
         clr_tgl_ff <= 1'b0;
      end else if (armed_ff) begin
         clr_tgl_ff <= ~clr_tgl_ff; // RULE_07 RULE_21
      end
   end

   // ---------------------------------------------------------------
   // Open-drain output stage.
   // ---------------------------------------------------------------
   logic drive_val;

   always_comb begin
      if (gate) begin
         drive_val = eflag_ff | cascade_serial_in; // RULE_11 RULE_15
      end else begin
         drive_val = out_ff; // RULE_19
      end
   end

   assign fault_output_pin_o    = 1'b0; // RULE_24
   assign fault_output_pin_oe_n = cs_n | drive_val; // RULE_14 RULE_24

endmodule : qdfsr_readout

// >>> qdfsr_readout_assertions.sv
// Concurrent checks on the ports of the fault readout block.
`timescale 1ns/10ps
module qdfsr_readout_assertions
   import qdfsr_pkg::*;
#(
   parameter int FILT_CYCLES = 4
)(
   // Core side
   input wire logic        core_clk,
   input wire logic        resetn,
   input wire logic [3:0]  over_temp_raw,
   input wire logic [3:0]  short_ground_raw,
   input wire logic [15:0] diag_reg_o,
   input wire logic        error_flag_o,
   // Link side
   input wire logic        spi_clk,
   input wire logic        cs_n,
   input wire logic        cascade_serial_in,
   input wire logic        fault_output_pin_o,
   input wire logic        fault_output_pin_oe_n
);
   logic [15:0] run_ff;
   logic        fresh_ff;

   default clocking @(posedge core_clk); endclocking
   default disable iff (!resetn);

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) run_ff <= 16'h0;
      else run_ff <= short_ground_raw[2] ? run_ff + 16'h1 : 16'h0;
   end

   // High from a deselect with the clock low until the first clock seen.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) fresh_ff <= 1'h0;
      else fresh_ff <= (cs_n | fresh_ff) & !spi_clk;
   end

   property p_release; cs_n |-> fault_output_pin_oe_n; endproperty
   a_release: assert property (p_release)
      else $error("pin driven while deselected");
   property p_drain; fault_output_pin_o == 1'h0; endproperty
   a_drain: assert property (p_drain)
      else $error("pin data not low");
   property p_latch;
      $rose(error_flag_o) |-> !cs_n && ($past(cs_n, 2) ||
         $past(cs_n, 3) || $past(cs_n, 4) || $past(cs_n, 5));
   endproperty
   a_latch: assert property (p_latch)
      else $error("flag moved outside select fall");
   property p_src; $rose(error_flag_o) |-> |diag_reg_o; endproperty
   a_src: assert property (p_src)
      else $error("flag without stored fault");
   property p_filter; $rose(diag_reg_o[5]) |-> run_ff >= FILT_CYCLES;
   endproperty
   a_filter: assert property (p_filter)
      else $error("ground short stored too early");
   property p_direct;
      $rose(over_temp_raw[0]) ##1 over_temp_raw[0] [*4] |=> diag_reg_o[15];
   endproperty
   a_direct: assert property (p_direct)
      else $error("over temperature not stored");
   property p_gate;
      fresh_ff && !cs_n && !spi_clk && cascade_serial_in
         |-> fault_output_pin_oe_n;
   endproperty
   a_gate: assert property (p_gate)
      else $error("cascade flag not passed");
   property p_clear;
      $rose(spi_clk) && fresh_ff && !cs_n |-> ##[1:8] !error_flag_o;
   endproperty
   a_clear: assert property (p_clear)
      else $error("flag not cleared by clock");
   property p_hold;
      !cs_n && !fresh_ff && !spi_clk && !$past(spi_clk) && !$past(cs_n)
         |-> $stable(fault_output_pin_oe_n);
   endproperty
   a_hold: assert property (p_hold)
      else $error("data moved with clock low");
endmodule : qdfsr_readout_assertions

bind qdfsr_readout qdfsr_readout_assertions #(.FILT_CYCLES(FILT_CYCLES))
   u_chk (.core_clk(core_clk), .resetn(resetn),
   .over_temp_raw(over_temp_raw), .short_ground_raw(short_ground_raw),
   .diag_reg_o(diag_reg_o), .error_flag_o(error_flag_o),
   .spi_clk(spi_clk), .cs_n(cs_n), .cascade_serial_in(cascade_serial_in),
   .fault_output_pin_o(fault_output_pin_o),
   .fault_output_pin_oe_n(fault_output_pin_oe_n));

// >>> qdfsr_readout_tb.sv
// Self-checking bench for the fault readout block.
`timescale 1ns/10ps
module qdfsr_readout_tb;
   import qdfsr_pkg::*;
   localparam int FC = 4;
   logic        core_clk;
   logic        resetn;
   logic        din;
   logic [3:0]  ot;
   logic [3:0]  sb;
   logic [3:0]  sg;
   logic [3:0]  ol;
   logic        spi_clk;
   logic        cs_n;
   logic        oe_n;
   logic        eflag;
   logic [15:0] diag;
   logic        flag;
   logic [31:0] d;
   int          bad_count;
   int          comparisons;
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin bad_count++; \
   $display("Error t=%0t got %h exp %h", $time, (a), (e)); end end

   qdfsr_readout #(.FILT_CYCLES(FC)) u_dut (
      .core_clk(core_clk), .resetn(resetn), .over_temp_raw(ot),
      .short_supply_raw(sb), .short_ground_raw(sg), .open_load_raw(ol),
      .spi_clk(spi_clk), .cs_n(cs_n), .cascade_serial_in(din),
      .fault_output_pin_o(), .fault_output_pin_oe_n(oe_n),
      .error_flag_o(eflag), .diag_reg_o(diag));
   qdfsr_host_model u_host (.spi_clk(spi_clk), .cs_n(cs_n),
      .pin_oe_n(oe_n));

   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask : cyc

   task automatic end_sim;
      $display("Checks %0d, errors %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : end_sim

   initial begin
      core_clk = 1'h0;
      forever #10 core_clk = ~core_clk;
   end

   initial begin
      #100000;
      bad_count++;
      end_sim();
   end

   initial begin
      resetn = 1'h0;
      din = 1'h0;
      ot = 4'h0;
      sb = 4'h0;
      sg = 4'h0;
      ol = 4'h0;
      bad_count = 0;
      comparisons = 0;
      cyc(10);
      resetn <= 1'h1;
      cyc(6);
      u_host.frame(0, 1'h0, flag, d);
      `CHK(flag, 1'h0)
      // A short open-load pulse must be filtered away.
      ol <= 4'h1;
      cyc(FC - 2);
      ol <= 4'h0;
      ot <= 4'h1;
      sg <= 4'h4;
      cyc(FC + 10);
      `CHK(diag, 16'h8020)
      `CHK(eflag, 1'h0)
      ot <= 4'h0;
      sg <= 4'h0;
      din <= 1'h1;
      cyc(2);
      fork
         u_host.frame(20, 1'h0, flag, d);
         begin
            cyc(150);
            sb <= 4'h2;
         end
      join
      `CHK(flag, 1'h1)
      `CHK(d[19:0], 20'h8020f)
      cyc(5);
      `CHK(diag, 16'h0400)
      `CHK(eflag, 1'h0)
      sb <= 4'h0;
      din <= 1'h0;
      cyc(2);
      u_host.frame(16, 1'h0, flag, d);
      `CHK(flag, 1'h1)
      `CHK(d[15:0], 16'h0400)
      `CHK(diag, 16'h0000)
      din <= 1'h1;
      cyc(2);
      u_host.frame(0, 1'h1, flag, d);
      `CHK(flag, 1'h0)
      u_host.frame(0, 1'h0, flag, d);
      `CHK(flag, 1'h1)
      end_sim();
   end
endmodule : qdfsr_readout_tb
